// *** sim/mfu_core_model.sv ***
// core model that accepts requests after a set delay
`timescale 1ns/1ns
module mfu_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request and acceptance
	input wire logic irq_req,
	input wire logic [3:0] ack_delay,
	output logic irq_ack
);
	logic [3:0] wait_ff, nxt_wait;
	logic ack_ff, nxt_ack;
	assign irq_ack = ack_ff;
	always_comb begin
		nxt_ack = 1'b0;
		nxt_wait = 4'h0;
		if (irq_req && !ack_ff) begin
			if (wait_ff == ack_delay) begin
				nxt_ack = 1'b1;
			end else begin
				nxt_wait = wait_ff + 4'h1;
			end
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_ff <= 4'h0;
			ack_ff <= 1'b0;
		end else begin
			wait_ff <= nxt_wait;
			ack_ff <= nxt_ack;
		end
	end
endmodule

// *** sim/mfu_irq_unit_bench.sv ***
// self-checking bench for the interrupt flag and mask unit
`timescale 1ns/1ns
module mfu_irq_unit_bench;
	import mfu_pkg::*;
	typedef struct {logic [6:0] ev; logic [3:0] pin; logic [5:0] addr; int b; logic [3:0] vec;} mfu_row_t;
	logic clk, rst, event_in_d, capture_en, watch_mode, cpu_wr, cpu_rd;
	logic irq_ack, irq_req, core_halt, core_wake, ev_edge;
	logic [8:0] evt;
	logic [3:0] pins, cpu_wdata, cpu_wmask, cpu_rdata, irq_vector, d, ack_delay;
	logic [5:0] cpu_addr;
	int failures, checks, edges;
	logic [5:0] rst_addr [9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h22, 6'h23, 6'h26, 6'h27, 6'h10};
	logic [3:0] rst_val [9] = '{4'h8, 4'ha, 4'ha, 4'ha, 4'ha, 4'ha, 4'h0, 4'h0, 4'h0};
	mfu_row_t rows [11] = '{'{7'h01, 4'h0, 6'h01, 2, 4'h6}, '{7'h02, 4'h0, 6'h02, 0, 4'h8},
		'{7'h04, 4'h0, 6'h02, 2, 4'ha}, '{7'h08, 4'h0, 6'h03, 0, 4'hc}, '{7'h10, 4'h0, 6'h23, 0, 4'hc},
		'{7'h20, 4'h0, 6'h03, 2, 4'he}, '{7'h40, 4'h0, 6'h23, 2, 4'he}, '{7'h00, 4'h1, 6'h00, 2, 4'h2},
		'{7'h00, 4'h2, 6'h01, 0, 4'h4}, '{7'h00, 4'h4, 6'h22, 0, 4'h8}, '{7'h00, 4'h8, 6'h22, 2, 4'ha}};

	mfu_irq_unit DUT (.clk(clk), .rst(rst), .ext_irq_0_n(pins[0]), .ext_irq_1_n(pins[1]),
		.ext_irq_2(pins[2]), .ext_irq_3(pins[3]), .event_in_d(event_in_d), .timer_a_ovf(evt[0]),
		.timer_b_ovf(evt[1]), .timer_c_ovf(evt[2]), .timer_d_ovf(evt[3]), .capture_en(capture_en),
		.serial1_done(evt[5]), .serial2_done(evt[6]), .adc_done(evt[4]), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
		.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wmask(cpu_wmask), .cpu_rdata(cpu_rdata),
		.standby_instr(evt[7]), .return_from_irq_instr(evt[8]), .irq_ack(irq_ack), .watch_mode(watch_mode),
		.irq_req(irq_req), .irq_vector(irq_vector), .core_halt(core_halt), .core_wake(core_wake),
		.event_edge(ev_edge));
	mfu_core_model model_i (.clk(clk), .rst(rst), .irq_req(irq_req), .ack_delay(ack_delay), .irq_ack(irq_ack));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// capture pulses counted mid-cycle, where they are settled
	always @(negedge clk) begin
		if (ev_edge === 1'b1) begin
			edges++;
		end
	end

	// ----------------------------------------
	// bus, event and check tasks
	// ----------------------------------------
	task wrap_up;
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr(input logic [5:0] a, input logic [3:0] v, input logic [3:0] m);
		@(posedge clk);
		cpu_wr <= 1'b1;
		cpu_addr <= a;
		cpu_wdata <= v;
		cpu_wmask <= m;
		@(posedge clk);
		cpu_wr <= 1'b0;
	endtask
	task rd(input logic [5:0] a);
		@(posedge clk);
		cpu_rd <= 1'b1;
		cpu_addr <= a;
		@(posedge clk);
		cpu_rd <= 1'b0;
		@(posedge clk);
		#1;
		d = cpu_rdata;
	endtask
	task fire(input logic [8:0] e, input logic [3:0] p);
		@(posedge clk);
		evt <= e;
		pins <= pins ^ p;
		@(posedge clk);
		evt <= 9'h000;
	endtask
	task await(input int which);
		int i;
		i = 0;
		#1;
		while ((which == 0 ? irq_req : which == 1 ? irq_ack : core_wake) !== 1'b1 && i < 40) begin
			@(posedge clk);
			#1;
			i++;
		end
		chk("handshake", (i < 40) ? 4'h1 : 4'h0, 4'h1);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		evt = 9'h000;
		pins = 4'h7;
		{event_in_d, capture_en, watch_mode, cpu_wr, cpu_rd} = 5'h00;
		cpu_addr = 6'h00;
		cpu_wdata = 4'h0;
		cpu_wmask = 4'h0;
		ack_delay = 4'h2;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		foreach (rst_addr[i]) begin
			rd(rst_addr[i]);
			chk("reset word", d, rst_val[i]);
		end
		wr(6'h26, 4'h9, 4'hf);
		wr(6'h00, 4'h1, 4'h1);
		foreach (rows[r]) begin
			wr(rows[r].addr, 4'h0, 4'h2 << rows[r].b);
			ack_delay <= r[0] ? 4'h5 : 4'h2;
			fire({2'h0, rows[r].ev}, rows[r].pin);
			await(0);
			chk("vector", irq_vector, rows[r].vec);
			await(1);
			@(posedge clk);
			#1;
			chk("req after ack", {3'h0, irq_req}, 4'h0);
			rd(rows[r].addr);
			chk("flag", d & (4'h3 << rows[r].b), 4'h1 << rows[r].b);
			wr(rows[r].addr, 4'h2 << rows[r].b, 4'h3 << rows[r].b);
			fire(9'h100, 4'h0);
		end
		for (int c = 0; c < 4; c++) begin
			wr(6'h26, {2'b10, c[1:0]}, 4'hf);
			repeat (2) begin
				fire(9'h000, 4'h4);
				repeat (4) @(posedge clk);
				rd(6'h22);
				chk("pin2 flag", {3'h0, d[0]}, {3'h0, pins[2] ? c[1] : c[0]});
				chk("masked req", {3'h0, irq_req}, 4'h0);
				wr(6'h22, 4'h2, 4'h3);
			end
		end
		capture_en <= 1'b1;
		wr(6'h27, 4'h7, 4'hf);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			event_in_d <= ~event_in_d;
			repeat (4) @(posedge clk);
			rd(6'h03);
			chk("capture flag", {3'h0, d[0]}, {3'h0, k[0]});
			chk("event edge", edges[3:0], {3'h0, k[0]});
		end
		wr(6'h03, 4'h2, 4'h3);
		wr(6'h01, 4'h0, 4'h8);
		wr(6'h02, 4'h0, 4'h2);
		fire(9'h003, 4'h0);
		await(0);
		chk("first vector", irq_vector, 4'h6);
		await(1);
		wr(6'h01, 4'h8, 4'hc);
		fire(9'h100, 4'h0);
		await(0);
		chk("second vector", irq_vector, 4'h8);
		await(1);
		wr(6'h02, 4'h0, 4'h1);
		fork
			wr(6'h02, 4'h0, 4'h4);
			fire(9'h004, 4'h0);
		join
		rd(6'h02);
		chk("set over clear", {3'h0, d[2]}, 4'h1);
		wr(6'h02, 4'h0, 4'h4);
		wr(6'h02, 4'h4, 4'h4);
		rd(6'h02);
		chk("software set", {3'h0, d[2]}, 4'h0);
		fire(9'h080, 4'h0);
		#1;
		chk("halt", {3'h0, core_halt}, 4'h1);
		fire(9'h002, 4'h0);
		await(2);
		@(posedge clk);
		#1;
		chk("pending", {2'h0, core_halt, irq_req}, 4'h0);
		rd(6'h02);
		chk("flag in standby", {3'h0, d[0]}, 4'h1);
		wr(6'h00, 4'h1, 4'h1);
		await(0);
		chk("pending vector", irq_vector, 4'h8);
		await(1);
		wr(6'h02, 4'h2, 4'h3);
		fire(9'h100, 4'h0);
		watch_mode <= 1'b1;
		fire(9'h07e, 4'h0);
		rd(6'h02);
		chk("watch word2", d & 4'h5, 4'h0);
		rd(6'h23);
		chk("watch word23", d & 4'h5, 4'h0);
		// watch standby: second pin stays asleep, timer A wakes
		fire(9'h000, 4'h2);
		wr(6'h01, 4'h0, 4'ha);
		fire(9'h080, 4'h0);
		fire(9'h000, 4'h2);
		repeat (4) @(posedge clk);
		#1;
		chk("watch halt", {3'h0, core_halt}, 4'h1);
		fire(9'h001, 4'h0);
		await(2);
		await(0);
		chk("watch vector", irq_vector, 4'h4);
		await(1);
		watch_mode <= 1'b0;
		// mid-run reset with flags still pending
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (rst_addr[i]) begin
			rd(rst_addr[i]);
			chk("reset again", d, rst_val[i]);
		end
		wrap_up;
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		wrap_up;
	end
endmodule

// *** sim/mfu_irq_unit_sva.sv ***
// port assertions for the interrupt flag and mask unit
`timescale 1ns/1ns
module mfu_irq_unit_chk
	import mfu_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// core access
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [mfu_pkg::AW-1:0] cpu_addr,
	input wire logic [3:0] cpu_rdata,
	// core events and results
	input wire logic standby_instr,
	input wire logic return_from_irq_instr,
	input wire logic irq_ack,
	input wire logic irq_req,
	input wire logic [3:0] irq_vector,
	input wire logic core_halt,
	input wire logic core_wake
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_acked;
		irq_ack && !return_from_irq_instr ##1 !return_from_irq_instr && !cpu_wr;
	endsequence
	sequence s_resume;
		!core_halt ##1 !core_halt && !core_wake;
	endsequence
	sequence s_bad_rd;
		cpu_rd && !(cpu_addr inside {6'h00, 6'h01, 6'h02, 6'h03, 6'h22, 6'h23}) ##1 !cpu_rd;
	endsequence
	chk_ack_drop: assert property (irq_ack && !return_from_irq_instr |=> !irq_req)
		else $error("request still high after ack");
	chk_ack_holds: assert property (s_acked |=> !irq_req)
		else $error("request back before return");
	chk_vec_range: assert property (irq_req |-> !irq_vector[0] && irq_vector != 4'h0)
		else $error("vector outside the even range");
	chk_halt_cause: assert property ($rose(core_halt) |-> $past(standby_instr))
		else $error("halt without standby");
	chk_wake_exit: assert property (core_wake |-> s_resume)
		else $error("wake not followed by active state");
	chk_wake_cause: assert property ($rose(core_wake) |-> $past(core_halt))
		else $error("wake while not halted");
	chk_halt_no_req: assert property (core_halt |-> !irq_req)
		else $error("request dispatched while halted");
	chk_wo_read: assert property (s_bad_rd |=> cpu_rdata == 4'h0)
		else $error("unreadable location returned data");
endmodule

bind mfu_irq_unit mfu_irq_unit_chk chk_i (.clk(clk), .rst(rst), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
	.cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .standby_instr(standby_instr),
	.return_from_irq_instr(return_from_irq_instr), .irq_ack(irq_ack), .irq_req(irq_req),
	.irq_vector(irq_vector), .core_halt(core_halt), .core_wake(core_wake));

// *** verilog/mfu_edge_det.sv ***
// pin synchroniser with selectable edge detection
`timescale 1ns/1ns
module mfu_edge_det
	import mfu_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pin and selection
	input wire logic pin,
	input wire mfu_pkg::mfu_edge_t sel,
	// detected edge, one cycle
	output logic edge_pulse
);

	// ---------------------------------------------------------------
	// synchroniser and history
	// ---------------------------------------------------------------
	logic meta_ff;
	logic sync_ff;
	logic hist_ff;
	logic nxt_meta;
	logic nxt_sync;
	logic nxt_hist;
	logic fall;
	logic rise;

	always_comb begin
		nxt_meta = pin;
		nxt_sync = meta_ff;
		nxt_hist = sync_ff;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			hist_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			hist_ff <= nxt_hist;
		end
	end

	// ---------------------------------------------------------------
	// edge decode
	// ---------------------------------------------------------------
	always_comb begin
		fall = hist_ff & ~sync_ff; // RULE_18
		rise = ~hist_ff & sync_ff; // RULE_18
		case (sel)
			EDGE_FALL: edge_pulse = fall;
			EDGE_RISE: edge_pulse = rise;
			EDGE_BOTH: edge_pulse = fall | rise;
			default: edge_pulse = 1'b0;
		endcase
	end

endmodule

// *** verilog/mfu_irq_unit.sv ***
// interrupt request flags, masks, edge select and standby wake
`timescale 1ns/1ns
module mfu_irq_unit
	import mfu_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// external pins
	input wire logic ext_irq_0_n,
	input wire logic ext_irq_1_n,
	input wire logic ext_irq_2,
	input wire logic ext_irq_3,
	input wire logic event_in_d,
	// peripheral event pulses
	input wire logic timer_a_ovf,
	input wire logic timer_b_ovf,
	input wire logic timer_c_ovf,
	input wire logic timer_d_ovf,
	input wire logic capture_en,
	input wire logic serial1_done,
	input wire logic serial2_done,
	input wire logic adc_done,
	// core bit-addressable access
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [mfu_pkg::AW-1:0] cpu_addr,
	input wire logic [3:0] cpu_wdata,
	input wire logic [3:0] cpu_wmask,
	output logic [3:0] cpu_rdata,
	// core instruction events and mode
	input wire logic standby_instr,
	input wire logic return_from_irq_instr,
	input wire logic irq_ack,
	input wire logic watch_mode,
	// dispatch and run control
	output logic irq_req,
	output logic [3:0] irq_vector,
	output logic core_halt,
	output logic core_wake,
	output logic event_edge
);

	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	function automatic logic [3:0] group_vector(input logic [2:0] g);
		group_vector = VEC_STEP * ({1'b0, g} + 4'h1); // RULE_16
	endfunction

	function automatic logic in_word(input logic [AW-1:0] a, input int s);
		in_word = (a == FLAG_ADDR[s]);
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic irq_en_ff;
	logic nxt_irq_en;
	logic [NSRC-1:0] flag_ff;
	logic [NSRC-1:0] nxt_flag;
	logic [NSRC-1:0] mask_ff;
	logic [NSRC-1:0] nxt_mask;
	logic [3:0] pin_sel_ff;
	logic [3:0] nxt_pin_sel;
	logic [1:0] ev_sel_ff;
	logic [1:0] nxt_ev_sel;
	logic [3:0] rdata_ff;
	logic [3:0] nxt_rdata;
	logic req_ff;
	logic nxt_req;
	logic [3:0] vec_ff;
	logic [3:0] nxt_vec;
	mfu_state_t state_ff;
	mfu_state_t nxt_state;

	logic [4:0] pin_vec;
	mfu_edge_t pin_sel [5];
	logic [4:0] pin_edge;
	logic [NSRC-1:0] set_ev;
	logic [NSRC-1:0] clr_ev;
	logic [NSRC-1:0] req_vec;
	logic [NGROUP-1:0] grp_req;
	logic any_req;
	logic wake_req;

	// ---------------------------------------------------------------
	// pin edge detectors
	// ---------------------------------------------------------------
	assign pin_vec = {event_in_d, ext_irq_3, ext_irq_2, ext_irq_1_n, ext_irq_0_n};

	always_comb begin
		pin_sel[0] = EDGE_FALL; // RULE_01
		pin_sel[1] = EDGE_FALL; // RULE_01
		pin_sel[2] = mfu_edge_t'(pin_sel_ff[PIN2_SEL_LSB +: 2]); // RULE_02
		pin_sel[3] = mfu_edge_t'(pin_sel_ff[PIN3_SEL_LSB +: 2]); // RULE_02
		pin_sel[4] = mfu_edge_t'(ev_sel_ff); // RULE_03
	end

	genvar gp;
	generate
		for (gp = 0; gp < 5; gp++) begin : g_pin
			mfu_edge_det u_det (
				.clk(clk),
				.rst(rst),
				.pin(pin_vec[gp]),
				.sel(pin_sel[gp]),
				.edge_pulse(pin_edge[gp])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// hardware set events
	// ---------------------------------------------------------------
	// flags keep collecting in standby since nothing here is halted
	always_comb begin
		set_ev = '0; // RULE_11
		set_ev[SRC_PIN0] = pin_edge[0]; // RULE_01
		set_ev[SRC_PIN1] = pin_edge[1]; // RULE_01
		set_ev[SRC_PIN2] = pin_edge[2]; // RULE_02
		set_ev[SRC_PIN3] = pin_edge[3]; // RULE_02
		set_ev[SRC_TA] = timer_a_ovf; // RULE_05
		set_ev[SRC_TB] = timer_b_ovf & ~watch_mode; // RULE_06 RULE_13
		set_ev[SRC_TC] = timer_c_ovf & ~watch_mode; // RULE_07 RULE_13
		set_ev[SRC_TD] = (timer_d_ovf | (capture_en & pin_edge[4])) & ~watch_mode; // RULE_08 RULE_13
		set_ev[SRC_S1] = serial1_done & ~watch_mode; // RULE_09 RULE_13
		set_ev[SRC_S2] = serial2_done & ~watch_mode; // RULE_09 RULE_13
		set_ev[SRC_AD] = adc_done & ~watch_mode; // RULE_10 RULE_13
	end

	// ---------------------------------------------------------------
	// flag and mask next values
	// ---------------------------------------------------------------
	// software writes of 0 clear a flag, writes of 1 do nothing
	always_comb begin
		nxt_flag = flag_ff;
		nxt_mask = mask_ff;
		clr_ev = '0;
		for (int s = 0; s < NSRC; s++) begin
			if (cpu_wr && in_word(cpu_addr, s)) begin
				if (cpu_wmask[FLAG_BIT[s]] && !cpu_wdata[FLAG_BIT[s]]) begin
					clr_ev[s] = 1'b1; // RULE_17
				end
				if (cpu_wmask[FLAG_BIT[s] + 2'h1]) begin
					nxt_mask[s] = cpu_wdata[FLAG_BIT[s] + 2'h1]; // RULE_04
				end
			end
			if (set_ev[s]) begin
				nxt_flag[s] = 1'b1; // RULE_19
			end else if (clr_ev[s]) begin
				nxt_flag[s] = 1'b0; // RULE_17
			end
		end
	end

	// ---------------------------------------------------------------
	// enable and edge select next values
	// ---------------------------------------------------------------
	always_comb begin
		nxt_irq_en = irq_en_ff;
		nxt_pin_sel = pin_sel_ff;
		nxt_ev_sel = ev_sel_ff;
		if (cpu_wr && cpu_addr == ADDR_WORD0 && cpu_wmask[ENABLE_BIT]) begin
			nxt_irq_en = cpu_wdata[ENABLE_BIT]; // RULE_14
		end
		if (cpu_wr && cpu_addr == ADDR_PIN_EDGE) begin
			for (int b = 0; b < 4; b++) begin
				if (cpu_wmask[b]) begin
					nxt_pin_sel[b] = cpu_wdata[b]; // RULE_02
				end
			end
		end
		if (cpu_wr && cpu_addr == ADDR_EVENT_EDGE) begin
			for (int b = 0; b < 2; b++) begin
				if (cpu_wmask[EVENT_SEL_LSB + b]) begin
					nxt_ev_sel[b] = cpu_wdata[EVENT_SEL_LSB + b]; // RULE_03
				end
			end
		end
		// accept clears, return sets; return wins over accept
		if (irq_ack) begin
			nxt_irq_en = 1'b0; // RULE_14
		end
		if (return_from_irq_instr) begin
			nxt_irq_en = 1'b1; // RULE_14
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	// edge select words are write-only and read as zero
	always_comb begin
		nxt_rdata = rdata_ff;
		if (cpu_rd) begin
			nxt_rdata = 4'h0;
			if (cpu_addr == ADDR_WORD0) begin
				nxt_rdata[ENABLE_BIT] = irq_en_ff;
			end
			for (int s = 0; s < NSRC; s++) begin
				if (in_word(cpu_addr, s)) begin
					nxt_rdata[FLAG_BIT[s]] = flag_ff[s];
					nxt_rdata[FLAG_BIT[s] + 2'h1] = mask_ff[s];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// request forming and priority
	// ---------------------------------------------------------------
	always_comb begin
		req_vec = flag_ff & ~mask_ff; // RULE_04 RULE_15
		grp_req = '0;
		for (int s = 0; s < NSRC; s++) begin
			if (req_vec[s]) begin
				grp_req[SRC_GROUP[s]] = 1'b1; // RULE_16
			end
		end
		any_req = |req_vec;
		// standby in watch mode is left only by timer A or the first pin
		if (watch_mode) begin
			wake_req = req_vec[SRC_PIN0] | req_vec[SRC_TA];
		end else begin
			wake_req = any_req;
		end
	end

	always_comb begin
		nxt_vec = vec_ff;
		for (int g = NGROUP - 1; g >= 0; g--) begin
			if (grp_req[g]) begin
				nxt_vec = group_vector(3'(g)); // RULE_16
			end
		end
		// dispatch only from active run with the enable set
		nxt_req = irq_en_ff & any_req & (state_ff == ST_ACTIVE) & ~irq_ack; // RULE_15 RULE_12
	end

	// ---------------------------------------------------------------
	// standby control
	// ---------------------------------------------------------------
	// a standby instruction with a request already waiting acts as no-op
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_ACTIVE: begin
				if (standby_instr && !any_req) begin
					nxt_state = ST_STANDBY;
				end
			end
			ST_STANDBY: begin
				if (wake_req) begin
					nxt_state = ST_WAKE; // RULE_12
				end
			end
			ST_WAKE: begin
				nxt_state = ST_ACTIVE; // RULE_12
			end
			default: begin
				nxt_state = ST_ACTIVE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_en_ff <= ENABLE_RESET; // RULE_17
			flag_ff <= FLAG_RESET; // RULE_17
			mask_ff <= MASK_RESET; // RULE_17
			pin_sel_ff <= EDGE_SEL_RESET;
			ev_sel_ff <= EDGE_SEL_RESET[EVENT_SEL_LSB +: 2];
			rdata_ff <= 4'h0;
			req_ff <= 1'b0;
			vec_ff <= 4'h0;
			state_ff <= ST_ACTIVE;
		end else begin
			irq_en_ff <= nxt_irq_en;
			flag_ff <= nxt_flag;
			mask_ff <= nxt_mask;
			pin_sel_ff <= nxt_pin_sel;
			ev_sel_ff <= nxt_ev_sel;
			rdata_ff <= nxt_rdata;
			req_ff <= nxt_req;
			vec_ff <= nxt_vec;
			state_ff <= nxt_state;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign cpu_rdata = rdata_ff;
	assign irq_req = req_ff;
	assign irq_vector = vec_ff;
	assign core_halt = (state_ff == ST_STANDBY);
	assign core_wake = (state_ff == ST_WAKE);
	assign event_edge = pin_edge[4];

endmodule

// *** verilog/mfu_pkg.sv ***
// constants for the interrupt flag and mask unit
//
// Contract
// RULE_01 - falling edge on ext_irq_0_n/ext_irq_1_n sets flag
// RULE_02 - pin_edge_select picks edges for ext_irq_2/3
// RULE_03 - event_edge_select bits 3:2 pick event_in_d edge
// RULE_04 - pin mask 1 blocks request, flag still sets
// RULE_05 - timer A overflow sets flag, mask bit 3
// RULE_06 - timer B overflow sets flag, mask bit 1
// RULE_07 - timer C overflow sets flag, mask bit 3
// RULE_08 - timer D overflow or capture edge sets flag
// RULE_09 - serial transfer end sets channel flag, mask bit 3
// RULE_10 - A/D completion sets flag, mask bit 1
// RULE_11 - flags keep setting while core is in standby
// RULE_12 - unmasked request ends standby; service needs enable; in watch mode only timer A or the first pin ends standby
// RULE_13 - watch mode silences timers B/C/D, A/D, serial
// RULE_14 - enable cleared on accept, set on return
// RULE_15 - request is flag and not mask; dispatch needs enable
// RULE_16 - fixed priority groups, vectors 2 to 14 step two
// RULE_17 - software only clears flags; reset clears, masks set
// RULE_18 - pins synchronised, edges from successive samples
// RULE_19 - hardware set beats software clear
package mfu_pkg;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam int AW = 6;
	localparam logic [AW-1:0] ADDR_WORD0 = 6'h00;
	localparam logic [AW-1:0] ADDR_WORD1 = 6'h01;
	localparam logic [AW-1:0] ADDR_WORD2 = 6'h02;
	localparam logic [AW-1:0] ADDR_WORD3 = 6'h03;
	localparam logic [AW-1:0] ADDR_WORD_EXT = 6'h22;
	localparam logic [AW-1:0] ADDR_WORD_EXT2 = 6'h23;
	localparam logic [AW-1:0] ADDR_PIN_EDGE = 6'h26;
	localparam logic [AW-1:0] ADDR_EVENT_EDGE = 6'h27;

	// ---------------------------------------------------------------
	// sources, in priority order within the flag vector
	// ---------------------------------------------------------------
	localparam int NSRC = 11;
	localparam int SRC_PIN0 = 0;
	localparam int SRC_PIN1 = 1;
	localparam int SRC_TA = 2;
	localparam int SRC_TB = 3;
	localparam int SRC_PIN2 = 4;
	localparam int SRC_TC = 5;
	localparam int SRC_PIN3 = 6;
	localparam int SRC_TD = 7;
	localparam int SRC_AD = 8;
	localparam int SRC_S1 = 9;
	localparam int SRC_S2 = 10;

	// word and bit of each flag; its mask sits one bit above
	localparam logic [AW-1:0] FLAG_ADDR [NSRC] = '{
		6'h00, 6'h01, 6'h01, 6'h02, 6'h22, 6'h02,
		6'h22, 6'h03, 6'h23, 6'h03, 6'h23};
	localparam logic [1:0] FLAG_BIT [NSRC] = '{
		2'h2, 2'h0, 2'h2, 2'h0, 2'h0, 2'h2,
		2'h2, 2'h0, 2'h0, 2'h2, 2'h2};
	// priority group of each source, 0 highest
	localparam logic [2:0] SRC_GROUP [NSRC] = '{
		3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4,
		3'h4, 3'h5, 3'h5, 3'h6, 3'h6};
	localparam int NGROUP = 7;

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int ENABLE_BIT = 0;
	localparam int PIN2_SEL_LSB = 0;
	localparam int PIN3_SEL_LSB = 2;
	localparam int EVENT_SEL_LSB = 2;
	localparam logic ENABLE_RESET = 1'b0;
	localparam logic [NSRC-1:0] FLAG_RESET = 11'h000;
	localparam logic [NSRC-1:0] MASK_RESET = 11'h7ff;
	localparam logic [3:0] EDGE_SEL_RESET = 4'h0;
	localparam logic [3:0] VEC_STEP = 4'h2;

	// ---------------------------------------------------------------
	// edge choices
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		EDGE_NONE = 2'h0,
		EDGE_FALL = 2'h1,
		EDGE_RISE = 2'h2,
		EDGE_BOTH = 2'h3
	} mfu_edge_t;

	// ---------------------------------------------------------------
	// core run state
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b00,
		ST_STANDBY = 2'b01,
		ST_WAKE = 2'b11
	} mfu_state_t;

endpackage
